/* File: shared/timer_two_pkg.sv */
// Purpose: Shared constants and types for the 16-bit capture/reload/baud timer
// Assumes: One clock at 125 MHz, 12 clocks per oscillator-divided tick
// Notes:   Register offsets are byte addresses on the special register port
package timer_two_pkg;

    // Register offsets on the special register port
    localparam logic [7:0] CONTROL_ADDR  = 8'hC8;
    localparam logic [7:0] CAP_LOW_ADDR  = 8'hCA;
    localparam logic [7:0] CAP_HIGH_ADDR = 8'hCB;
    localparam logic [7:0] CNT_LOW_ADDR  = 8'hCC;
    localparam logic [7:0] CNT_HIGH_ADDR = 8'hCD;

    // Control register field positions
    localparam int OVF_BIT  = 7;
    localparam int EXTF_BIT = 6;
    localparam int RCLK_BIT = 5;
    localparam int TX_CLOCK_SELECT_BIT = 4;
    localparam int EXEN_BIT = 3;
    localparam int RUN_BIT  = 2;
    localparam int SRC_BIT  = 1;
    localparam int CAPR_BIT = 0;

    // Values after reset
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // Clock cycles in one machine cycle (oscillator divided by twelve)
    localparam int          MACHINE_CYCLE_CLKS = 12;
    localparam logic [3:0]  TICK_LAST = 4'(MACHINE_CYCLE_CLKS - 1);

    // Operating mode
    typedef enum logic [1:0] {
        MODE_RELOAD,
        MODE_CAPTURE,
        MODE_BAUD,
        MODE_STOP
    } mode_t;

    // Control register fields
    typedef struct packed {
        logic overflow_flag;
        logic external_flag;
        logic rx_clock_select;
        logic tx_clock_select;
        logic ext_trigger_enable;
        logic run_control;
        logic count_source_select;
        logic capture_reload_select;
    } control_t;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Mode decode from control fields
    function automatic mode_t decode_mode(input control_t c);
        if (!c.run_control)
            return MODE_STOP;
        else if (c.rx_clock_select || c.tx_clock_select)
            return MODE_BAUD;
        else if (c.capture_reload_select)
            return MODE_CAPTURE;
        else
            return MODE_RELOAD;
    endfunction : decode_mode

endpackage : timer_two_pkg

/* File: core/timer_two_sampler.sv */
// Purpose: Machine-cycle sampler and falling edge finder for one input pin
// Assumes: Pin is synchronous to CLK; sample strobe is one clock wide
// Notes:   Edge is a high sample followed by a low sample one cycle later
module timer_two_sampler
    import timer_two_pkg::*;
(
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RESET_N,
    // Pin and sample strobe
    input  wire logic PIN,
    input  wire logic SAMPLE,
    // Falling edge pulse, one clock wide
    output logic      FALL
);

    logic prev_q;   // Previous machine-cycle sample
    logic prev_d;
    logic fall_q;   // Registered edge pulse
    logic fall_d;

    // Next sample and edge
    always_comb
    begin
        prev_d = prev_q;
        fall_d = 1'b0;
        if (SAMPLE)
        begin
            prev_d = PIN;
            fall_d = prev_q & ~PIN;
        end
    end

    // Sample registers
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Low after reset so a pin idling low gives no false edge
            prev_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
            fall_q <= fall_d;
        end
    end

    assign FALL = fall_q;

endmodule : timer_two_sampler

/* File: core/timer_two.sv */
// Purpose: 16-bit timer/counter with capture, auto-reload and baud modes
// Assumes: CPU reaches registers on a byte-wide special register port
// Notes:   Serial clock outputs are one-clock overflow pulses
// Overview of operation
// [R1] 16-bit up-counter, timer or event counter
// [R2] Source select: falling count edges or OSC/12
// [R3] Run bit starts and stops counting
// [R4] Mode decode from serial selects and capture
// [R5] Overflow flag set by hardware, not baud
// [R6] External flag set on trigger capture/reload
// [R7] Both flags share one interrupt request
// [R8] Receive clock from our overflow or other
// [R9] Transmit clock from our overflow or other
// [R10] Trigger ignored when disabled or baud
// [R11] Capture mode trigger copies count bytes
// [R12] Capture without trigger: plain overflowing counter
// [R13] Reload mode rollover reloads and flags
// [R14] Reload mode trigger reloads early, flags
// [R15] Baud mode always reloads on overflow
// [R16] Inputs sampled per machine cycle for edges
// [R17] Software presets reload, clears flags
module timer_two
    import timer_two_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    // Special register port
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    // External pins
    input  wire logic       COUNT_INPUT,
    input  wire logic       EXT_TRIGGER_INPUT,
    // Other timer overflow pulse
    input  wire logic       OTHER_TIMER_OVF,
    // Interrupt request to the CPU
    output logic            IRQ,
    // Serial port clock pulses
    output logic            RX_BAUD_CLK,
    output logic            TX_BAUD_CLK
);

    reg_req_t   req;             // Bundled register request
    control_t   ctrl_q;          // Control register
    control_t   ctrl_d;
    logic [15:0] count_q;        // Count high and low bytes
    logic [15:0] count_d;
    logic [15:0] cap_q;          // Capture/reload pair
    logic [15:0] cap_d;
    logic [3:0]  tick_q;         // Machine cycle divider
    logic [3:0]  tick_d;
    logic [7:0]  rdata_q;        // Registered read data
    logic [7:0]  rdata_d;
    logic        mc_strobe;      // One clock per machine cycle
    logic        count_fall;     // Falling edge on count input
    logic        trig_fall;      // Falling edge on trigger input
    logic        advance;        // Counter step this clock
    logic        overflow;       // Counter rolls over this clock
    logic        trig_act;       // Trigger edge takes effect
    mode_t       mode;           // Decoded mode

    assign req       = '{wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};
    assign mc_strobe = (tick_q == TICK_LAST);
    // [R4] decode operating mode
    assign mode      = decode_mode(ctrl_q);

    // [R16] count pin edge sampling
    timer_two_sampler u_count_sampler
    (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .PIN     (COUNT_INPUT),
        .SAMPLE  (mc_strobe),
        .FALL    (count_fall)
    );

    // [R16] trigger pin edge sampling
    timer_two_sampler u_trig_sampler
    (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .PIN     (EXT_TRIGGER_INPUT),
        .SAMPLE  (mc_strobe),
        .FALL    (trig_fall)
    );

    // Divider next value
    always_comb
    begin
        tick_d = mc_strobe ? 4'h0 : tick_q + 4'h1;
    end

    // Step, overflow and trigger qualification
    always_comb
    begin
        // [R1] [R2] timer or counter source
        if (ctrl_q.count_source_select)
            advance = count_fall;
        else
            advance = mc_strobe;
        // [R3] run bit gates counting
        advance  = advance & ctrl_q.run_control;
        overflow = advance & (count_q == 16'hFFFF);
        // [R10] trigger only when enabled, not baud
        trig_act = trig_fall & ctrl_q.ext_trigger_enable & (mode != MODE_BAUD)
                 & (mode != MODE_STOP);
    end

    // Counter and capture pair next values
    always_comb
    begin
        count_d = count_q;
        cap_d   = cap_q;
        if (advance)
            count_d = count_q + 16'h0001;
        case (mode)
            MODE_RELOAD:
            begin
                // [R13] reload on rollover
                if (overflow)
                    count_d = cap_q;
                // [R14] early reload on trigger
                if (trig_act)
                    count_d = cap_q;
            end
            MODE_CAPTURE:
            begin
                // [R11] capture current count
                if (trig_act)
                    cap_d = count_q;
                // [R12] plain rollover to zero otherwise
            end
            MODE_BAUD:
            begin
                // [R15] forced reload on overflow
                if (overflow)
                    count_d = cap_q;
            end
            MODE_STOP:
            begin
                // Nothing moves while stopped
            end
            default:
            begin
                count_d = count_q;
            end
        endcase
        // CPU writes to count and capture bytes
        if (req.wr)
        begin
            case (req.addr)
                CNT_LOW_ADDR:  count_d[7:0]  = req.wdata;
                CNT_HIGH_ADDR: count_d[15:8] = req.wdata;
                CAP_LOW_ADDR:  cap_d[7:0]    = req.wdata;
                CAP_HIGH_ADDR: cap_d[15:8]   = req.wdata;
                default:       ;
            endcase
        end
    end

    // Control register next value; hardware set wins over software clear
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (req.wr && req.addr == CONTROL_ADDR)
            ctrl_d = control_t'(req.wdata);
        // [R5] overflow flag, not in baud mode
        if (overflow && !ctrl_q.rx_clock_select && !ctrl_q.tx_clock_select)
            ctrl_d.overflow_flag = 1'b1;
        // [R6] external flag on capture or reload
        if (trig_act)
            ctrl_d.external_flag = 1'b1;
    end

    // Read data mux
    always_comb
    begin
        case (req.addr)
            CONTROL_ADDR:  rdata_d = ctrl_q;
            CNT_LOW_ADDR:  rdata_d = count_q[7:0];
            CNT_HIGH_ADDR: rdata_d = count_q[15:8];
            CAP_LOW_ADDR:  rdata_d = cap_q[7:0];
            CAP_HIGH_ADDR: rdata_d = cap_q[15:8];
            default:       rdata_d = 8'h00;
        endcase
    end

    // State registers
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ctrl_q  <= control_t'(CONTROL_RESET);
            count_q <= COUNT_RESET;
            cap_q   <= COUNT_RESET;
            tick_q  <= 4'h0;
            rdata_q <= 8'h00;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            count_q <= count_d;
            cap_q   <= cap_d;
            tick_q  <= tick_d;
            rdata_q <= rdata_d;
        end
    end

    // Register read data
    assign REG_RDATA = rdata_q;

    // [R7] shared interrupt request
    assign IRQ = ctrl_q.overflow_flag | ctrl_q.external_flag;

    // [R8] receive clock source select
    assign RX_BAUD_CLK = ctrl_q.rx_clock_select ? overflow : OTHER_TIMER_OVF;

    // [R9] transmit clock source select
    assign TX_BAUD_CLK = ctrl_q.tx_clock_select ? overflow : OTHER_TIMER_OVF;

endmodule : timer_two

/* File: tb/timer_two_assertions.sv */
// Purpose: Port assertions for the capture/reload/baud timer
// Assumes: Software control bits mirrored from register writes
// Notes:   Flag bits are set by hardware, so they are not mirrored
module timer_two_assertions
    import timer_two_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    // Register port
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_RDATA,
    // Pulses and request
    input  wire logic       OTHER_TIMER_OVF,
    input  wire logic       IRQ,
    input  wire logic       RX_BAUD_CLK,
    input  wire logic       TX_BAUD_CLK,
    input  wire logic [7:0] REG_WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] ctl_q; // Mirror: rx, tx, trigger, run, source, capture
    logic [5:0] ctl_d; // Next mirror value
    // Follow control writes
    always_comb
        ctl_d = (REG_WR && REG_ADDR == CONTROL_ADDR) ? REG_WDATA[5:0] : ctl_q;
    // Mirror register
    always_ff @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
            ctl_q <= 6'h00;
        else
            ctl_q <= ctl_d;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    property p_rx_other; !ctl_q[5] |-> RX_BAUD_CLK == OTHER_TIMER_OVF; endproperty
    property p_tx_other; !ctl_q[4] |-> TX_BAUD_CLK == OTHER_TIMER_OVF; endproperty
    property p_rx_pulse; ctl_q[5] && RX_BAUD_CLK |=> !RX_BAUD_CLK; endproperty
    property p_tx_pulse; ctl_q[4] && TX_BAUD_CLK |=> !TX_BAUD_CLK; endproperty
    property p_stop;
        !ctl_q[2] && !REG_WR && !$past(REG_WR) && REG_ADDR == CNT_LOW_ADDR
            && $past(REG_ADDR) == CNT_LOW_ADDR |=> $stable(REG_RDATA);
    endproperty
    property p_no_flag; (ctl_q[5] || ctl_q[4]) && !$past(REG_WR) |-> !$rose(IRQ); endproperty
    property p_ctrl; $past(REG_ADDR) == CONTROL_ADDR |-> REG_RDATA[5:0] == $past(ctl_q); endproperty
    property p_irq_fall; $fell(IRQ) |-> $past(REG_WR) && $past(REG_ADDR) == CONTROL_ADDR; endproperty
    a_rx_other: assert property (p_rx_other) else $error("rx clock not other timer");
    a_tx_other: assert property (p_tx_other) else $error("tx clock not other timer");
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse too long");
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx pulse too long");
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    a_no_flag: assert property (p_no_flag) else $error("flag set in baud mode");
    a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
    // Main scenarios reached
    c_baud: cover property (ctl_q[5] && RX_BAUD_CLK);
    c_irq: cover property ($rose(IRQ));
    c_other: cover property (!ctl_q[5] && OTHER_TIMER_OVF);
endmodule : timer_two_assertions

/* File: tb/serial_clock_model.sv */
// Purpose: Serial port clock inputs and other timer model
// Assumes: Serial port runs in a variable rate mode
// Notes:   Other timer overflows once per PERIOD clocks
module serial_clock_model
#(
    parameter int PERIOD = 20 // Other timer overflow spacing
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Baud pulses from the timer
    input  wire logic rx_baud_clk,
    input  wire logic tx_baud_clk,
    // Other timer pulse and pulse counts
    output logic      other_ovf,
    output int        rx_count,
    output int        tx_count,
    output int        other_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int div_q; // Other timer divider
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q <= 0;
            other_ovf <= 1'b0;
            rx_count <= 0;
            tx_count <= 0;
            other_count <= 0;
        end
        else
        begin
            div_q <= (div_q == PERIOD - 1) ? 0 : div_q + 1;
            other_ovf <= (div_q == PERIOD - 1);
            rx_count <= rx_count + int'(rx_baud_clk);
            tx_count <= tx_count + int'(tx_baud_clk);
            other_count <= other_count + int'(other_ovf);
        end
    end
endmodule : serial_clock_model

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the capture/reload/baud timer
// Assumes: Pins hold each level for two machine cycles or more
// Notes:   Expected values come from fixed presets
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_two_pkg::*;
    logic       clk = 1'b0, reset_n = 1'b0, wr = 1'b0, cnt_pin = 1'b0, trg_pin = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       irq, rx_clk, tx_clk, other_ovf;
    int         n_fail = 0, n_tests = 0, rx_count, tx_count, other_count, k, r0, t0, o0;
    logic [7:0] regs [6] = '{CONTROL_ADDR, CAP_LOW_ADDR, CAP_HIGH_ADDR, CNT_LOW_ADDR,
                             CNT_HIGH_ADDR, 8'hC9};
    // Device and serial side
    timer_two DUT (.CLK(clk), .RESET_N(reset_n), .REG_WR(wr), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .COUNT_INPUT(cnt_pin),
        .EXT_TRIGGER_INPUT(trg_pin), .OTHER_TIMER_OVF(other_ovf), .IRQ(irq),
        .RX_BAUD_CLK(rx_clk), .TX_BAUD_CLK(tx_clk));
    serial_clock_model PEER (.clk(clk), .reset_n(reset_n), .rx_baud_clk(rx_clk),
        .tx_baud_clk(tx_clk), .other_ovf(other_ovf), .rx_count(rx_count),
        .tx_count(tx_count), .other_count(other_count));
    initial forever #4 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {wr, addr, wdata} = {1'b1, a, d};
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        addr = a;
        @(posedge clk);
        #1;
        check(rdata, exp);
    endtask : rd_reg
    // One falling edge on the trigger or count pin
    task automatic fall(input bit trig);
        {trg_pin, cnt_pin} = {trig, !trig};
        repeat (24) @(posedge clk);
        #1;
        {trg_pin, cnt_pin} = 2'b00;
        repeat (36) @(posedge clk);
        #1;
    endtask : fall
    task automatic end_sim;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // Bounded wait for the interrupt request, a timeout counts as a failure
    task automatic wait_irq;
        for (k = 0; k < 100 && irq !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        if (k == 100)
        begin
            n_fail++;
            end_sim();
        end
    endtask : wait_irq
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        foreach (regs[i]) rd_reg(regs[i], 8'h00);
        // Timer overflow in capture mode
        wr_reg(CNT_LOW_ADDR, 8'hFE);
        wr_reg(CNT_HIGH_ADDR, 8'hFF);
        wr_reg(CONTROL_ADDR, 8'h05);
        wait_irq();
        rd_reg(CNT_HIGH_ADDR, 8'h00);
        rd_reg(CONTROL_ADDR, 8'h85);
        wr_reg(CONTROL_ADDR, 8'h00);
        check(8'(irq), 8'h00);
        wr_reg(CNT_LOW_ADDR, 8'h55);
        repeat (100) @(posedge clk);
        rd_reg(CNT_LOW_ADDR, 8'h55);
        // Trigger capture with counter held still
        wr_reg(CNT_LOW_ADDR, 8'h34);
        wr_reg(CNT_HIGH_ADDR, 8'h12);
        wr_reg(CONTROL_ADDR, 8'h0F);
        fall(1);
        rd_reg(CAP_LOW_ADDR, 8'h34);
        rd_reg(CAP_HIGH_ADDR, 8'h12);
        rd_reg(CONTROL_ADDR, 8'h4F);
        check(8'(irq), 8'h01);
        wr_reg(CONTROL_ADDR, 8'h0F);
        repeat (3) fall(0);
        rd_reg(CNT_LOW_ADDR, 8'h37);
        // Early reload, then trigger disabled
        wr_reg(CAP_LOW_ADDR, 8'h00);
        wr_reg(CAP_HIGH_ADDR, 8'hAB);
        wr_reg(CONTROL_ADDR, 8'h0E);
        fall(1);
        rd_reg(CNT_HIGH_ADDR, 8'hAB);
        rd_reg(CONTROL_ADDR, 8'h4E);
        wr_reg(CONTROL_ADDR, 8'h06);
        wr_reg(CNT_LOW_ADDR, 8'h11);
        fall(1);
        rd_reg(CNT_LOW_ADDR, 8'h11);
        // Rollover in reload mode loads the preset pair
        wr_reg(CNT_LOW_ADDR, 8'hFF);
        wr_reg(CNT_HIGH_ADDR, 8'hFF);
        wr_reg(CONTROL_ADDR, 8'h04);
        wait_irq();
        rd_reg(CNT_HIGH_ADDR, 8'hAB);
        rd_reg(CONTROL_ADDR, 8'h84);
        wr_reg(CONTROL_ADDR, 8'h00);
        // Baud generation, trigger ignored
        wr_reg(CAP_LOW_ADDR, 8'hFA);
        wr_reg(CAP_HIGH_ADDR, 8'hFF);
        wr_reg(CNT_LOW_ADDR, 8'hFA);
        wr_reg(CNT_HIGH_ADDR, 8'hFF);
        wr_reg(CONTROL_ADDR, 8'h3C);
        {r0, t0} = {rx_count, tx_count};
        fall(1);
        repeat (600) @(posedge clk);
        #1;
        check(8'(tx_count - t0), 8'(rx_count - r0));
        check(8'(rx_count - r0 > 7), 8'h01);
        rd_reg(CNT_HIGH_ADDR, 8'hFF);
        rd_reg(CONTROL_ADDR, 8'h3C);
        // Other timer clocks the serial port
        wr_reg(CONTROL_ADDR, 8'h00);
        {r0, o0} = {rx_count, other_count};
        repeat (200) @(posedge clk);
        #1;
        check(8'(rx_count - r0), 8'(other_count - o0));
        end_sim();
    end
endmodule : tb_top
bind timer_two timer_two_assertions chk (.CLK(CLK), .RESET_N(RESET_N), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .OTHER_TIMER_OVF(OTHER_TIMER_OVF),
    .IRQ(IRQ), .RX_BAUD_CLK(RX_BAUD_CLK), .TX_BAUD_CLK(TX_BAUD_CLK), .REG_WDATA(REG_WDATA));
